// *** dtc_timer.sv ***
// two 16-bit timer/counters, 13-bit and 16-bit modes, with register port
//
// Behaviour
// - each timer is 16-bit, high and low bytes
// - irq only when timer irq enable set
// - two-bit mode field per timer selects mode
// - 13-bit mode: high byte plus low bits 4..0
// - low byte bits 7..5 undefined in 13-bit
// - overflow sets flag, requests enabled irq
// - counter select 1 counts pin falling edges
// - counter select 0 counts internal clock
// - count only when run and gate satisfied
// - gate input active while high
// - run does not clear count, resumes
// - internal clock is sysclk or sysclk/12
// - timer mode toggle inverts pin on overflow
// - toggle enable makes pin an output
// - 16-bit mode uses all sixteen bits
// - code 00 is 13-bit, 01 16-bit
// - flag cleared by software, software set interrupts
`timescale 1ns/10ps

module dtc_timer
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input dtc_pkg::dtc_bus_s regBus,
   output logic [7:0] rdData_q,
   input wire logic [1:0] cntPinIn,
   input wire logic [1:0] gatePinIn,
   output logic [1:0] cntPinOut_q,
   output logic [1:0] cntPinOe_n_q,
   output logic [1:0] timerIrq_q
);

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic [7:0] countLow_q [2]; // count_low_byte per timer
   logic [7:0] countHigh_q [2]; // count_high_byte per timer
   logic [1:0] run_q; // run_bit per timer
   logic [1:0] flag_q; // overflow_flag per timer
   logic [3:0] extIrqBits_q; // low nibble of run/flag reg, storage only
   logic [7:0] mode_q; // timer_mode_register
   logic [3:0] clkPin_q; // timer_clock_pin_register, low nibble
   logic [7:0] irqEn_q; // interrupt_enable_register
   logic [3:0] preCnt_q; // /12 divider

   // ----------------------------------------------------------------
   // per-timer decoded controls
   // ----------------------------------------------------------------
   logic [1:0] gateBit; // gate_bit
   logic [1:0] ctSel; // 1 = counter on pin edges
   logic [1:0] fastClk; // prescale_select: 1 = full sysclk
   logic [1:0] toggleEn; // pin_toggle_enable
   logic [1:0] irqEn; // per-timer interrupt enable
   logic [1:0] modeOk; // a supported mode is chosen
   logic [1:0] is13; // 13-bit mode
   logic [1:0] cntFall; // synchronised falling edge of count pin
   logic [1:0] gateLvl; // synchronised gate input level
   logic [1:0] tick; // one count step this cycle
   logic [1:0] ovf; // count wraps this cycle
   logic [1:0] wrLow; // software writes low byte
   logic [1:0] wrHigh; // software writes high byte
   logic [7:0] nextLow [2]; // incremented low byte
   logic [7:0] nextHigh [2]; // incremented high byte
   logic preTick; // slow clock enable pulse
   logic wrRunFlags; // write to run/flag register

   assign wrRunFlags = regBus.wr && (regBus.addr == dtc_pkg::ADDR_RUN_FLAGS);
   assign preTick = (preCnt_q == dtc_pkg::PRESCALE_DIV - 4'h1);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   for (genvar t = 0; t < 2; t++)
   begin : g_pin
      // count pin: only the edge is used
      dtc_sync_edge u_cnt
      (
         .clk_sys(clk_sys),
         .sys_rst(sys_rst),
         .pinIn(cntPinIn[t]),
         .level(),
         .fall(cntFall[t])
      );
      // gate pin: only the level is used
      dtc_sync_edge u_gate
      (
         .clk_sys(clk_sys),
         .sys_rst(sys_rst),
         .pinIn(gatePinIn[t]),
         .level(gateLvl[t]),
         .fall()
      );
   end

   // ----------------------------------------------------------------
   // count path, combinational
   // ----------------------------------------------------------------
   // decode fields, pick clock source, form next count and overflow
   always_comb
   begin
      logic [1:0] mf;
      logic [12:0] c13;
      logic [15:0] c16;
      mf = 2'h0;
      c13 = 13'h0;
      c16 = 16'h0;
      for (int t = 0; t < 2; t++)
      begin
         mf = mode_q[t*dtc_pkg::MODE_NIBBLE +: 2];
         gateBit[t] = mode_q[t*dtc_pkg::MODE_NIBBLE + dtc_pkg::GATE_POS];
         ctSel[t] = mode_q[t*dtc_pkg::MODE_NIBBLE + dtc_pkg::CT_POS];
         fastClk[t] = clkPin_q[dtc_pkg::PRESCALE_POS0 + t];
         toggleEn[t] = clkPin_q[dtc_pkg::TOGGLE_POS0 + t];
         is13[t] = (mf == dtc_pkg::MODE_13BIT);
         // reload and split modes are not built: timer holds
         modeOk[t] = is13[t] || (mf == dtc_pkg::MODE_16BIT);
         // run and gate; gate input is active high
         tick[t] = run_q[t] && (!gateBit[t] || gateLvl[t]) && modeOk[t];
         if (ctSel[t])
            tick[t] = tick[t] && cntFall[t];
         else
            tick[t] = tick[t] && (fastClk[t] || preTick);
         c13 = {countHigh_q[t], countLow_q[t][4:0]} + 13'h1;
         c16 = {countHigh_q[t], countLow_q[t]} + 16'h1;
         if (is13[t])
         begin
            // bits 7..5 of low byte are left as they are
            nextLow[t] = {countLow_q[t][7:5], c13[4:0]};
            nextHigh[t] = c13[12:5];
            ovf[t] = tick[t] && ({countHigh_q[t], countLow_q[t][4:0]} == dtc_pkg::MAX13);
         end
         else
         begin
            nextLow[t] = c16[7:0];
            nextHigh[t] = c16[15:8];
            ovf[t] = tick[t] && ({countHigh_q[t], countLow_q[t]} == 16'hffff);
         end
      end
   end

   // byte write decodes per timer
   assign wrLow[0] = regBus.wr && (regBus.addr == dtc_pkg::ADDR_LOW0);
   assign wrLow[1] = regBus.wr && (regBus.addr == dtc_pkg::ADDR_LOW1);
   assign wrHigh[0] = regBus.wr && (regBus.addr == dtc_pkg::ADDR_HIGH0);
   assign wrHigh[1] = regBus.wr && (regBus.addr == dtc_pkg::ADDR_HIGH1);

   // ----------------------------------------------------------------
   // prescaler
   // ----------------------------------------------------------------
   // free-running /12, shared by both timers
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         preCnt_q <= 4'h0;
      else if (preTick)
         preCnt_q <= 4'h0;
      else
         preCnt_q <= preCnt_q + 4'h1;
   end

   // ----------------------------------------------------------------
   // count registers
   // ----------------------------------------------------------------
   // software write wins over a step in the same cycle;
   // run never clears the count, so it resumes where it stopped
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         for (int t = 0; t < 2; t++)
         begin
            countLow_q[t] <= dtc_pkg::RST_BYTE;
            countHigh_q[t] <= dtc_pkg::RST_BYTE;
         end
      end
      else
      begin
         for (int t = 0; t < 2; t++)
         begin
            if (wrLow[t])
               countLow_q[t] <= regBus.wdata;
            else if (tick[t])
               countLow_q[t] <= nextLow[t];
            if (wrHigh[t])
               countHigh_q[t] <= regBus.wdata;
            else if (tick[t])
               countHigh_q[t] <= nextHigh[t];
         end
      end
   end

   // ----------------------------------------------------------------
   // run bits and overflow flags
   // ----------------------------------------------------------------
   // overflow set beats a software clear in the same cycle
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         run_q <= 2'h0;
         flag_q <= 2'h0;
         extIrqBits_q <= 4'h0;
      end
      else
      begin
         for (int t = 0; t < 2; t++)
         begin
            if (wrRunFlags)
               run_q[t] <= regBus.wdata[dtc_pkg::RUN_BIT_POS0 + t*dtc_pkg::TIMER_STRIDE];
            if (ovf[t])
               flag_q[t] <= 1'b1;
            else if (wrRunFlags)
               flag_q[t] <= regBus.wdata[dtc_pkg::FLAG_POS0 + t*dtc_pkg::TIMER_STRIDE];
         end
         // external interrupt bits live here but belong elsewhere
         if (wrRunFlags)
            extIrqBits_q <= regBus.wdata[3:0];
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   // mode, clock/pin and interrupt enable: plain read/write storage
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         mode_q <= dtc_pkg::RST_BYTE;
         clkPin_q <= 4'h0;
         irqEn_q <= dtc_pkg::RST_BYTE;
      end
      else if (regBus.wr)
      begin
         unique case (regBus.addr)
            dtc_pkg::ADDR_MODE: mode_q <= regBus.wdata;
            dtc_pkg::ADDR_CLK_PIN: clkPin_q <= regBus.wdata[3:0];
            dtc_pkg::ADDR_IRQ_EN: irqEn_q <= regBus.wdata;
            default: ; // other addresses leave these alone
         endcase
      end
   end

   assign irqEn[0] = irqEn_q[dtc_pkg::IRQ_EN_POS0];
   assign irqEn[1] = irqEn_q[dtc_pkg::IRQ_EN_POS1];

   // ----------------------------------------------------------------
   // interrupt requests
   // ----------------------------------------------------------------
   // flag set by hardware or software both request, if enabled
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         timerIrq_q <= 2'h0;
      else
         timerIrq_q <= flag_q & irqEn;
   end

   // ----------------------------------------------------------------
   // count pin drive
   // ----------------------------------------------------------------
   // direction follows toggle enable with no port write needed;
   // toggling is limited to timer operation, not pin counting
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cntPinOut_q <= {2{dtc_pkg::RST_PIN_LEVEL}};
         cntPinOe_n_q <= 2'h3;
      end
      else
      begin
         for (int t = 0; t < 2; t++)
         begin
            cntPinOe_n_q[t] <= !toggleEn[t];
            if (ovf[t] && toggleEn[t] && !ctSel[t])
               cntPinOut_q[t] <= !cntPinOut_q[t];
         end
      end
   end

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   // data stands one cycle after the strobe, zero otherwise
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         rdData_q <= dtc_pkg::RST_BYTE;
      else if (regBus.rd)
      begin
         unique case (regBus.addr)
            dtc_pkg::ADDR_RUN_FLAGS:
               rdData_q <= {flag_q[1], run_q[1], flag_q[0], run_q[0], extIrqBits_q};
            dtc_pkg::ADDR_MODE: rdData_q <= mode_q;
            dtc_pkg::ADDR_LOW0: rdData_q <= countLow_q[0];
            dtc_pkg::ADDR_LOW1: rdData_q <= countLow_q[1];
            dtc_pkg::ADDR_HIGH0: rdData_q <= countHigh_q[0];
            dtc_pkg::ADDR_HIGH1: rdData_q <= countHigh_q[1];
            dtc_pkg::ADDR_CLK_PIN: rdData_q <= {4'h0, clkPin_q};
            dtc_pkg::ADDR_IRQ_EN: rdData_q <= irqEn_q;
            default: rdData_q <= 8'h00; // unmapped reads zero
         endcase
      end
      else
         rdData_q <= 8'h00;
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   a_ovf_sets_flag: assert property (ovf[0] |=> flag_q[0])
      else $error("overflow did not set flag");

   a_irq_enabled: assert property (ovf[1] && irqEn[1] && !regBus.wr
      |-> ##2 timerIrq_q[1])
      else $error("enabled overflow gave no irq");

   a_irq_masked: assert property (!$past(irqEn[0]) |-> !timerIrq_q[0])
      else $error("irq raised while disabled");

   a_hold_stopped: assert property (!run_q[0] && !wrLow[0] |=> $stable(countLow_q[0]))
      else $error("count moved while stopped");

   a_gate_blocks: assert property (gateBit[0] && !gateLvl[0] |-> !tick[0])
      else $error("count stepped with gate low");

   a_pin_edge_only: assert property (ctSel[1] && tick[1] |-> cntFall[1])
      else $error("counter stepped without pin edge");

   a_slow_spacing: assert property (preTick |=> !preTick [*8])
      else $error("prescale pulses too close");

   a_wrap_13: assert property (is13[1] && ovf[1] && !wrLow[1] && !wrHigh[1]
      |=> countHigh_q[1] == 8'h00 && countLow_q[1][4:0] == 5'h00)
      else $error("13-bit overflow did not wrap to zero");

   a_pin_toggles: assert property (ovf[0] && toggleEn[0] && !ctSel[0]
      |=> cntPinOut_q[0] != $past(cntPinOut_q[0]))
      else $error("pin did not toggle on overflow");

   a_pin_dir: assert property (toggleEn[1] |=> !cntPinOe_n_q[1])
      else $error("pin not driven with toggle enabled");

   c_ovf_16: cover property (!is13[0] && ovf[0]);
   c_ovf_13_counter: cover property (is13[1] && ctSel[1] && ovf[1]);
   c_gated_count: cover property (gateBit[0] && tick[0]);
   c_irq: cover property (timerIrq_q[0]);

endmodule // dtc_timer

// *** dtc_pkg.sv ***
// shared constants and types of the dual timer/counter block
package dtc_pkg;

   // ----------------------------------------------------------------
   // register addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_RUN_FLAGS = 8'h88; // timer_run_flags_register
   localparam logic [7:0] ADDR_MODE = 8'h89; // timer_mode_register
   localparam logic [7:0] ADDR_LOW0 = 8'h8a; // count_low_byte, timer 0
   localparam logic [7:0] ADDR_LOW1 = 8'h8b; // count_low_byte, timer 1
   localparam logic [7:0] ADDR_HIGH0 = 8'h8c; // count_high_byte, timer 0
   localparam logic [7:0] ADDR_HIGH1 = 8'h8d; // count_high_byte, timer 1
   localparam logic [7:0] ADDR_CLK_PIN = 8'hce; // timer_clock_pin_register
   localparam logic [7:0] ADDR_IRQ_EN = 8'ha8; // interrupt_enable_register

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int RUN_BIT_POS0 = 4; // run_bit of timer 0, timer 1 is +2
   localparam int FLAG_POS0 = 5; // overflow_flag of timer 0, timer 1 is +2
   localparam int TIMER_STRIDE = 2; // spacing of per-timer bits in run/flag reg
   localparam int MODE_NIBBLE = 4; // width of one timer's mode nibble
   localparam int GATE_POS = 3; // gate_bit inside a mode nibble
   localparam int CT_POS = 2; // counter/timer select inside a nibble
   localparam int PRESCALE_POS0 = 2; // prescale_select of timer 0
   localparam int TOGGLE_POS0 = 0; // pin_toggle_enable of timer 0
   localparam int IRQ_EN_POS0 = 1; // first_timer_irq_enable
   localparam int IRQ_EN_POS1 = 3; // second_timer_irq_enable

   // ----------------------------------------------------------------
   // reset values and timing
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00; // all mapped registers clear
   localparam logic RST_PIN_LEVEL = 1'b1; // toggled pin idles high
   localparam logic [3:0] PRESCALE_DIV = 4'hc; // slow clock is sysclk / 12
   localparam logic [12:0] MAX13 = 13'h1fff; // last count of the 13-bit mode

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      MODE_13BIT = 2'h0,
      MODE_16BIT = 2'h1,
      MODE_RELOAD = 2'h2,
      MODE_SPLIT = 2'h3
   } dtc_mode_e; // mode_select_field codes

   typedef struct packed
   {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } dtc_bus_s; // register port request

endpackage

// *** dtc_sync_edge.sv ***
// two-stage pin synchroniser with falling edge detect
`timescale 1ns/10ps

module dtc_sync_edge
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic pinIn,
   output logic level,
   output logic fall
);

   // ----------------------------------------------------------------
   // synchroniser and history
   // ----------------------------------------------------------------
   logic meta_q; // first stage, read only by second
   logic sync_q; // second stage, safe level
   logic prev_q; // previous safe sample

   // pins float in from outside, so two flops before any logic
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end
      else
      begin
         meta_q <= pinIn;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign level = sync_q;
   // one pulse per detected high-to-low step
   assign fall = prev_q & ~sync_q;

   a_fall_once: assert property (@(posedge clk_sys) disable iff (sys_rst)
      fall |=> !fall)
      else $error("fall pulse longer than one cycle");

endmodule // dtc_sync_edge

// *** dtc_pin_model.sv ***
// far-side model: pulse source on the count pins and gate levels
`timescale 1ns/10ps

module dtc_pin_model
(
   input wire logic clk_sys,
   input wire logic [1:0] genOn,
   input wire logic [1:0] gateWant,
   input wire logic [1:0] devOut,
   input wire logic [1:0] devOe_n,
   output logic [1:0] pinLevel,
   output logic [1:0] gateLevel
);
   // ------------------------------------------------
   // pulse source
   // ------------------------------------------------
   logic [7:0] phase [2]; // pulse phase per pin
   logic [1:0] srcLvl; // level the source would put out

   // phase restarts per burst, so every burst begins high
   always_ff @(posedge clk_sys)
   begin
      for (int i = 0; i < 2; i++)
      begin
         phase[i] <= genOn[i] ? phase[i] + 8'h01 : 8'h00;
      end
   end

   // four-cycle period, low for two: one fall per period
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         srcLvl[i] = !(genOn[i] && phase[i][1]);
      end
   end

   // ------------------------------------------------
   // wire resolution
   // ------------------------------------------------
   // device drive wins; an idle pin rests at its pull-up
   assign pinLevel = (devOe_n & srcLvl) | (~devOe_n & devOut);
   assign gateLevel = gateWant;
endmodule // dtc_pin_model

// *** tb_top.sv ***
// self-checking bench for the dual timer/counter
`timescale 1ns/10ps

module tb_top;
   // ------------------------------------------------
   // signals
   // ------------------------------------------------
   logic clk_sys; // 50 MHz system clock
   logic sys_rst; // active-high reset
   dtc_pkg::dtc_bus_s regBus; // register request
   logic [7:0] rdData_q; // read data
   logic [1:0] cntPinIn, gatePinIn, cntPinOut_q, cntPinOe_n_q, timerIrq_q;
   logic [1:0] genOn, gateWant; // partner controls
   int errors, checks_done; // tallies
   logic [15:0] cnt; // count read back
   logic [7:0] d; // scratch byte

   dtc_timer dtc_timer_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .regBus(regBus),
      .rdData_q(rdData_q), .cntPinIn(cntPinIn), .gatePinIn(gatePinIn),
      .cntPinOut_q(cntPinOut_q), .cntPinOe_n_q(cntPinOe_n_q), .timerIrq_q(timerIrq_q));

   dtc_pin_model dtc_pin_model_inst (.clk_sys(clk_sys), .genOn(genOn), .gateWant(gateWant),
      .devOut(cntPinOut_q), .devOe_n(cntPinOe_n_q), .pinLevel(cntPinIn), .gateLevel(gatePinIn));

   // free-running clock
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one-cycle write; idle edge after it keeps assignments apart
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      regBus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      regBus <= '0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      regBus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      regBus <= '0;
      #1 v = rdData_q;
   endtask

   task automatic load(input int t, input logic [15:0] v);
      wr(dtc_pkg::ADDR_HIGH0 + 8'(t), v[15:8]);
      wr(dtc_pkg::ADDR_LOW0 + 8'(t), v[7:0]);
   endtask

   task automatic rdCnt(input int t);
      rd(dtc_pkg::ADDR_LOW0 + 8'(t), cnt[7:0]);
      rd(dtc_pkg::ADDR_HIGH0 + 8'(t), cnt[15:8]);
   endtask

   // run window: on-write, k idle edges, off-write gives k+2 steps
   task automatic runFor(input logic [7:0] runVal, input int k);
      wr(dtc_pkg::ADDR_RUN_FLAGS, runVal);
      repeat (k) @(posedge clk_sys);
      wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h00);
   endtask

   // ------------------------------------------------
   // scenarios
   // ------------------------------------------------
   task automatic t_reset;
      logic [7:0] al [9];
      al = '{dtc_pkg::ADDR_RUN_FLAGS, dtc_pkg::ADDR_MODE, dtc_pkg::ADDR_LOW0,
         dtc_pkg::ADDR_LOW1, dtc_pkg::ADDR_HIGH0, dtc_pkg::ADDR_HIGH1,
         dtc_pkg::ADDR_CLK_PIN, dtc_pkg::ADDR_IRQ_EN, 8'h90};
      #1 chk("pin out", cntPinOut_q, 2'b11);
      chk("pin oe_n", cntPinOe_n_q, 2'b11);
      chk("irq", timerIrq_q, 2'b00);
      for (int i = 0; i < 9; i++)
      begin
         rd(al[i], d);
         chk("reset value", d, 8'h00);
      end
      // data bytes hold whatever software writes
      for (int i = 2; i < 6; i++)
      begin
         wr(al[i], 8'h3c ^ 8'(i));
         rd(al[i], d);
         chk("data byte", d, 8'h3c ^ 8'(i));
      end
      wr(8'h90, 8'hff);
      rd(8'h90, d);
      chk("unmapped", d, 8'h00);
   endtask

   task automatic t_wrap16;
      wr(dtc_pkg::ADDR_MODE, 8'h01);
      wr(dtc_pkg::ADDR_IRQ_EN, 8'h02);
      wr(dtc_pkg::ADDR_CLK_PIN, 8'h05);
      load(0, 16'hfff0);
      #1 chk("pin oe_n", cntPinOe_n_q[0], 1'b0);
      chk("pin idle", cntPinOut_q[0], 1'b1);
      wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h10);
      repeat (30) @(posedge clk_sys);
      #1 chk("irq after ovf", timerIrq_q[0], 1'b1);
      chk("pin toggled", cntPinOut_q[0], 1'b0);
      wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h00);
      rdCnt(0);
      chk("wrap16", cnt, 16'h0010);
      chk("irq cleared", timerIrq_q[0], 1'b0);
   endtask

   task automatic t_mode13;
      wr(dtc_pkg::ADDR_MODE, 8'h00);
      // timer 1 fast clock with pin toggle: one overflow drives the pin low
      wr(dtc_pkg::ADDR_CLK_PIN, 8'h0a);
      load(1, 16'hfff8);
      wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h40);
      repeat (14) @(posedge clk_sys);
      rd(dtc_pkg::ADDR_RUN_FLAGS, d);
      chk("flag1", d, 8'hc0);
      chk("irq masked", timerIrq_q[1], 1'b0);
      chk("pin1 toggled", cntPinOut_q[1], 1'b0);
      chk("pin1 oe_n", cntPinOe_n_q[1], 1'b0);
      wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h00);
      rdCnt(1);
      // upper three low-byte bits carry no meaning here
      chk("wrap13", {cnt[15:8], cnt[4:0]}, 13'h000a);
      runFor(8'h40, 0);
      rdCnt(1);
      chk("resume", {cnt[15:8], cnt[4:0]}, 13'h000c);
   endtask

   task automatic t_prescale;
      wr(dtc_pkg::ADDR_MODE, 8'h01);
      wr(dtc_pkg::ADDR_CLK_PIN, 8'h00);
      load(0, 16'h0000);
      // any 120 straight cycles hold ten divider ticks
      runFor(8'h10, 118);
      rdCnt(0);
      chk("div12", cnt, 16'h000a);
   endtask

   task automatic t_gate;
      wr(dtc_pkg::ADDR_MODE, 8'h09);
      wr(dtc_pkg::ADDR_CLK_PIN, 8'h04);
      load(0, 16'h0000);
      runFor(8'h10, 8);
      rdCnt(0);
      chk("gate low", cnt, 16'h0000);
      @(posedge clk_sys);
      gateWant <= 2'b01;
      repeat (4) @(posedge clk_sys);
      runFor(8'h10, 8);
      rdCnt(0);
      chk("gate high", cnt, 16'h000a);
      @(posedge clk_sys);
      gateWant <= 2'b00;
   endtask

   task automatic t_count;
      // timer 1: pin counter in the 13-bit mode, its irq enabled
      wr(dtc_pkg::ADDR_MODE, 8'h40);
      wr(dtc_pkg::ADDR_IRQ_EN, 8'h08);
      load(1, 16'hfffe);
      wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h40);
      @(posedge clk_sys);
      genOn <= 2'b10;
      repeat (20) @(posedge clk_sys);
      genOn <= 2'b00;
      repeat (6) @(posedge clk_sys);
      #1 chk("irq1 enabled", timerIrq_q[1], 1'b1);
      wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h00);
      rdCnt(1);
      // five falls from 1ffe wrap once and land on 3
      chk("pin falls", {cnt[15:8], cnt[4:0]}, 13'h0003);
   endtask

   task automatic t_swflag;
      wr(dtc_pkg::ADDR_IRQ_EN, 8'h02);
      wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h20);
      repeat (2) @(posedge clk_sys);
      #1 chk("sw flag irq", timerIrq_q[0], 1'b1);
      wr(dtc_pkg::ADDR_IRQ_EN, 8'h00);
      repeat (2) @(posedge clk_sys);
      #1 chk("irq disabled", timerIrq_q[0], 1'b0);
      wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h00);
      // unbuilt mode code must leave the count alone
      wr(dtc_pkg::ADDR_MODE, 8'h20);
      load(1, 16'h0123);
      runFor(8'h40, 8);
      rdCnt(1);
      chk("mode 10 holds", cnt, 16'h0123);
      wr(dtc_pkg::ADDR_MODE, 8'h30);
      runFor(8'h40, 8);
      rdCnt(1);
      chk("mode 11 holds", cnt, 16'h0123);
   endtask

   // ------------------------------------------------
   // verdict
   // ------------------------------------------------
   task automatic results;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // watchdog: whole run needs well under 3000 cycles
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      results();
   end

   // main sequence
   initial
   begin
      regBus = '0;
      genOn = 2'b00;
      gateWant = 2'b00;
      errors = 0;
      checks_done = 0;
      sys_rst = 1'b1;
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_reset();
      t_wrap16();
      t_mode13();
      t_prescale();
      t_gate();
      t_count();
      t_swflag();
      results();
   end
endmodule // tb_top
